// File: include/tw_pkg.sv
package tw_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned SYS_CLK_PERIOD_PS = 5000;
  localparam int unsigned STD_BIT_NS = 10000;
  localparam int unsigned FAST_BIT_NS = 2500;
  localparam int unsigned PHASES_PER_BIT = 4;
  localparam int unsigned CNT_W = 10;
  // Quarter-bit counts, rounded up so the bit is never faster than the mode allows
  localparam logic [CNT_W-1:0] STD_QTR_CYC =
    CNT_W'((STD_BIT_NS * 1000 + PHASES_PER_BIT * SYS_CLK_PERIOD_PS - 1) / (PHASES_PER_BIT * SYS_CLK_PERIOD_PS));
  localparam logic [CNT_W-1:0] FAST_QTR_CYC =
    CNT_W'((FAST_BIT_NS * 1000 + PHASES_PER_BIT * SYS_CLK_PERIOD_PS - 1) / (PHASES_PER_BIT * SYS_CLK_PERIOD_PS));

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned TXBUF_W = 32;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] PH0 = 2'h0;
  localparam logic [1:0] PH1 = 2'h1;
  localparam logic [1:0] PH2 = 2'h2;
  localparam logic [1:0] PH3 = 2'h3;

  typedef enum logic [2:0] {
    TW_IDLE  = 3'h0,
    TW_START = 3'h1,
    TW_WRITE = 3'h3,
    TW_ACK   = 3'h2,
    TW_STOP  = 3'h6,
    TW_READ  = 3'h7
  } tw_state_e_t;

  // Command word: start, stop, read, write, and the acknowledge level sent when reading
  typedef struct packed {
    logic start;
    logic stop;
    logic read;
    logic write;
    logic ack;
  } tw_cmd_t;

  localparam tw_cmd_t CMD_NONE = '0;

  // Status flags toward software
  typedef struct packed {
    logic tip;
    logic done;
    logic al;
    logic rxack;
    logic busy;
  } tw_status_t;

endpackage : tw_pkg

// File: design/tw_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tw_sync
  import tw_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '1
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tw_sync_t;

  tw_sync_t st_ff;
  tw_sync_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = i_d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_q = st_ff.s2;

endmodule : tw_sync

`default_nettype wire

// File: design/tw_master.sv
`timescale 1ns/1ps
`default_nettype none

module tw_master
  import tw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_fast_mode,
  input wire logic i_cmd_valid,
  input wire tw_cmd_t i_cmd,
  input wire logic [TXBUF_W-1:0] i_tx_data,
  input wire logic [1:0] i_tx_num,
  input wire logic i_done_clr,
  input wire logic i_al_clr,
  output logic [BYTE_W-1:0] o_rx_data,
  output tw_status_t o_status,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_sync_ff <= 2'h0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ************************************************************
  // Line sampling
  // ************************************************************
  logic [1:0] line_s;
  logic scl_s;
  logic sda_s;

  tw_sync #(.W(2), .RST_VAL(2'h3)) u_line_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_d({i_scl, i_sda}),
    .o_q(line_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    tw_state_e_t st;
    logic [1:0] ph;
    logic [CNT_W-1:0] cnt;
    logic [2:0] bitn;
    logic [BYTE_W-1:0] sh;
    logic [1:0] left;
    logic [TXBUF_W-1:0] tx;
    logic [BYTE_W-1:0] rx;
    tw_cmd_t cmd;
    logic own;
    logic scl_oe;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    tw_status_t stat;
  } tw_state_t;

  tw_state_t st_ff;
  tw_state_t nxt_st;
  logic [CNT_W-1:0] qtr;
  logic tick;
  logic start_seen;
  logic stop_seen;

  assign qtr = i_fast_mode ? FAST_QTR_CYC : STD_QTR_CYC;
  // High phase holds while a slave keeps the clock low
  assign tick = (st_ff.cnt == qtr) && (st_ff.ph != PH2 || scl_s);
  assign start_seen = scl_s && st_ff.scl_d && st_ff.sda_d && !sda_s;
  assign stop_seen = scl_s && st_ff.scl_d && !st_ff.sda_d && sda_s;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.scl_d = scl_s;
    nxt_st.sda_d = sda_s;
    nxt_st.cnt = tick ? '0 : st_ff.cnt + CNT_W'(1);
    if (st_ff.ph == PH2 && !scl_s)
    begin
      nxt_st.cnt = '0;
    end
    if (tick)
    begin
      nxt_st.ph = st_ff.ph + 2'h1;
    end

    if (start_seen)
    begin
      nxt_st.stat.busy = 1'b1;
    end
    else if (stop_seen)
    begin
      nxt_st.stat.busy = 1'b0;
    end

    // Set wins over clear
    if (i_done_clr)
    begin
      nxt_st.stat.done = 1'b0;
    end
    if (i_al_clr)
    begin
      nxt_st.stat.al = 1'b0;
    end

    unique case (st_ff.st)
      TW_IDLE:
      begin
        nxt_st.ph = PH0;
        nxt_st.cnt = '0;
        if (i_cmd_valid && !st_ff.stat.tip && i_en)
        begin
          nxt_st.cmd = i_cmd;
          nxt_st.tx = i_tx_data;
          nxt_st.left = i_tx_num;
          // Start without a direction is dropped
          nxt_st.stat.tip = !(i_cmd.start && !i_cmd.read && !i_cmd.write)
                            && (i_cmd != CMD_NONE);
        end
        else if (st_ff.stat.tip)
        begin
          if (st_ff.cmd.start)
          begin
            // Own bus: clock held low, repeated start; else wait for idle
            if (st_ff.own || (!st_ff.stat.busy && scl_s && sda_s))
            begin
              nxt_st.st = TW_START;
            end
          end
          else if (st_ff.cmd.write)
          begin
            nxt_st.st = TW_WRITE;
            nxt_st.sh = st_ff.tx[BYTE_W-1:0];
            nxt_st.bitn = '0;
          end
          else if (st_ff.cmd.read)
          begin
            nxt_st.st = TW_READ;
            nxt_st.bitn = '0;
          end
          else if (st_ff.cmd.stop && st_ff.own)
          begin
            nxt_st.st = TW_STOP;
          end
          else
          begin
            nxt_st.stat.tip = 1'b0;
            nxt_st.stat.done = 1'b1;
          end
        end
      end

      TW_START:
      begin
        if (tick)
        begin
          unique case (st_ff.ph)
            PH0: nxt_st.sda_oe = 1'b0;
            PH1: nxt_st.scl_oe = 1'b0;
            PH2:
            begin
              if (!sda_s)
              begin
                nxt_st = lose(nxt_st);
              end
              else
              begin
                nxt_st.sda_oe = 1'b1;
                nxt_st.own = 1'b1;
              end
            end
            PH3:
            begin
              nxt_st.scl_oe = 1'b1;
              nxt_st.cmd.start = 1'b0;
              nxt_st.st = TW_IDLE;
            end
          endcase
        end
      end

      TW_WRITE, TW_READ:
      begin
        if (tick)
        begin
          unique case (st_ff.ph)
            PH0: nxt_st.sda_oe = (st_ff.st == TW_WRITE) ? !st_ff.sh[BYTE_W-1] : 1'b0;
            PH1: nxt_st.scl_oe = 1'b0;
            PH2:
            begin
              if (st_ff.st == TW_WRITE && !st_ff.sda_oe && !sda_s)
              begin
                nxt_st = lose(nxt_st);
              end
              else
              begin
                nxt_st.sh = {st_ff.sh[BYTE_W-2:0], sda_s};
              end
            end
            PH3:
            begin
              nxt_st.scl_oe = 1'b1;
              nxt_st.bitn = st_ff.bitn + 3'h1;
              if (st_ff.bitn == LAST_BIT)
              begin
                nxt_st.st = TW_ACK;
                if (st_ff.st == TW_READ)
                begin
                  nxt_st.rx = st_ff.sh;
                end
              end
            end
          endcase
        end
      end

      TW_ACK:
      begin
        if (tick)
        begin
          unique case (st_ff.ph)
            PH0: nxt_st.sda_oe = st_ff.cmd.read ? !st_ff.cmd.ack : 1'b0;
            PH1: nxt_st.scl_oe = 1'b0;
            PH2:
            begin
              if (!st_ff.cmd.read)
              begin
                nxt_st.stat.rxack = sda_s;
              end
            end
            PH3:
            begin
              nxt_st.scl_oe = 1'b1;
              // Data kept until the low phase; moving it with the clock edge could fake a stop
              if (!st_ff.cmd.read && st_ff.left != 2'h0 && !st_ff.stat.rxack)
              begin
                nxt_st.left = st_ff.left - 2'h1;
                nxt_st.tx = st_ff.tx >> BYTE_W;
                nxt_st.sh = st_ff.tx[2*BYTE_W-1:BYTE_W];
                nxt_st.st = TW_WRITE;
              end
              else if (st_ff.cmd.stop)
              begin
                nxt_st.st = TW_STOP;
              end
              else
              begin
                // Bus kept; software decides stop or repeated start
                nxt_st.st = TW_IDLE;
                nxt_st.stat.tip = 1'b0;
                nxt_st.stat.done = 1'b1;
              end
            end
          endcase
        end
      end

      TW_STOP:
      begin
        if (tick)
        begin
          unique case (st_ff.ph)
            PH0: nxt_st.sda_oe = 1'b1;
            PH1: nxt_st.scl_oe = 1'b0;
            PH2: nxt_st.sda_oe = 1'b0;
            PH3:
            begin
              nxt_st.own = 1'b0;
              nxt_st.st = TW_IDLE;
              nxt_st.stat.tip = 1'b0;
              nxt_st.stat.done = 1'b1;
            end
          endcase
        end
      end

      default:
      begin
        nxt_st.st = TW_IDLE;
      end
    endcase

    if (!i_en)
    begin
      nxt_st.st = TW_IDLE;
      nxt_st.scl_oe = 1'b0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.own = 1'b0;
      nxt_st.stat.tip = 1'b0;
      nxt_st.stat.busy = 1'b0;
    end
  end

  // Release both lines and end the transfer
  function automatic tw_state_t lose(input tw_state_t s);
    tw_state_t r;
    r = s;
    r.scl_oe = 1'b0;
    r.sda_oe = 1'b0;
    r.own = 1'b0;
    r.st = TW_IDLE;
    r.stat.tip = 1'b0;
    r.stat.done = 1'b1;
    r.stat.al = 1'b1;
    return r;
  endfunction : lose

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '{st: TW_IDLE, ph: PH0, cnt: '0, bitn: '0, sh: '0, left: '0, tx: '0, rx: '0,
                 cmd: CMD_NONE, own: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0, scl_d: 1'b1, sda_d: 1'b1,
                 stat: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Lines are never driven high; the pull-up makes the one
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe = st_ff.scl_oe;
  assign o_sda_oe = st_ff.sda_oe;
  assign o_rx_data = st_ff.rx;
  assign o_status = st_ff.stat;

endmodule : tw_master

`default_nettype wire

// File: bench/tw_master_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tw_master_asserts
  import tw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_fast_mode,
  input wire logic i_cmd_valid,
  input wire tw_cmd_t i_cmd,
  input wire logic i_done_clr,
  input wire tw_status_t o_status,
  input wire logic i_scl,
  input wire logic o_scl_o,
  input wire logic o_scl_oe,
  input wire logic o_sda_o,
  input wire logic o_sda_oe
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] hi_cnt;
  logic taken;
  assign taken = i_cmd_valid && !o_status.tip && i_en;
  // Raw line high time; the design sees it later through its synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) hi_cnt <= '0;
    else if (!i_scl) hi_cnt <= '0;
    else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h1;
  end
  sequence s_sda_pull;
    $rose(o_sda_oe) && !o_scl_oe;
  endsequence
  sequence s_sda_free;
    $fell(o_sda_oe) && !$past(o_scl_oe) && i_en;
  endsequence
  a_lines_low_only: assert property (!o_scl_o && !o_sda_o) else $error("line driven high");
  a_cmd_starts: assert property (taken && i_cmd.start && (i_cmd.read || i_cmd.write) |=> o_status.tip)
    else $error("start command not taken");
  a_start_needs_rw: assert property (taken && i_cmd == tw_cmd_t'(5'h10) |=> !o_status.tip)
    else $error("bare start was taken");
  a_finish_done: assert property ($fell(o_status.tip) && i_en |-> o_status.done)
    else $error("finished without done");
  a_done_sticky: assert property (o_status.done && !i_done_clr |=> o_status.done)
    else $error("done lost");
  a_start_scl_high: assert property (s_sda_pull |-> i_scl) else $error("start with clock low");
  a_stop_scl_high: assert property (s_sda_free |-> i_scl) else $error("stop with clock low");
  a_high_phase: assert property ($rose(o_scl_oe) && i_en |-> hi_cnt >= (i_fast_mode ? FAST_QTR_CYC : STD_QTR_CYC))
    else $error("clock high phase too short");
  a_al_cancel: assert property ($rose(o_status.al) |-> ##[0:1] (!o_sda_oe && !o_scl_oe && !o_status.tip))
    else $error("transfer kept after lost arbitration");
endmodule : tw_master_asserts
bind tw_master tw_master_asserts chk_u (.*);
`default_nettype wire

// File: bench/tw_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] RD_BYTE = 8'hA5
)
(
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_stretch,
  output logic o_scl_pull,
  output logic o_sda_pull,
  output logic [7:0] o_last
);
  // ********************
  // Slave behaviour
  // ********************
  int bitn = 0;
  logic adr = 1'b0, sel = 1'b0, rd = 1'b0;
  logic [7:0] sh = '0;
  initial {o_scl_pull, o_sda_pull, o_last} = '0;
  always @(negedge i_sda) if (i_scl)
  begin
    bitn = 0;
    adr = 1'b1;
    sel = 1'b0;
    o_sda_pull = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) {adr, sel} = 2'h0;
  always @(posedge i_scl)
  begin
    if (bitn < 8) sh = {sh[6:0], i_sda};
    else if (sel && rd && i_sda) sel = 1'b0; // Master refused: let go of the line
    bitn++;
  end
  // Lines change only while the clock is low; only ever pulled low
  always @(negedge i_scl)
  begin
    if (bitn == 9)
    begin
      bitn = 0;
      if (adr) {sel, rd, adr} = {sh[7:1] == ADDR, sh[0], 1'b0};
    end
    if (bitn == 8)
    begin
      o_sda_pull = (adr && sh[7:1] == ADDR) || (sel && !rd);
      if (sel && !rd) o_last = sh;
    end
    else o_sda_pull = sel && rd && bitn < 8 && !RD_BYTE[7 - bitn];
    if (i_stretch)
    begin
      o_scl_pull = 1'b1;
      #2000;
      o_scl_pull = 1'b0;
    end
  end
endmodule : tw_slave_model
`default_nettype wire

// File: bench/tw_master_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tw_master_tb;
  import tw_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, fast = 1'b1, valid = 1'b0, dclr = 1'b0, aclr = 1'b0;
  logic tb_pull = 1'b0, stretch = 1'b0, scl_o, sda_o, scl_oe, sda_oe, s_scl, s_sda, scl_w, sda_w;
  tw_cmd_t cmd = CMD_NONE;
  logic [31:0] tx = '0;
  logic [1:0] num = '0;
  logic [7:0] rx, last;
  tw_status_t st;
  int n_errors = 0, tests_run = 0;
  // Pull-ups: a released line reads high
  assign scl_w = !(scl_oe || s_scl);
  assign sda_w = !(sda_oe || s_sda || tb_pull);
  always #2.5 clk = ~clk;
  tw_master dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_en(1'b1), .i_fast_mode(fast), .i_cmd_valid(valid),
    .i_cmd(cmd), .i_tx_data(tx), .i_tx_num(num), .i_done_clr(dclr), .i_al_clr(aclr), .o_rx_data(rx),
    .o_status(st), .i_scl(scl_w), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe));
  tw_slave_model #(.ADDR(7'h2A), .RD_BYTE(8'hA5)) slave_u (.i_scl(scl_w), .i_sda(sda_w), .i_stretch(stretch),
    .o_scl_pull(s_scl), .o_sda_pull(s_sda), .o_last(last));
  // ********************
  // Tasks
  // ********************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : check
  task automatic run(input logic [4:0] c, input logic [31:0] d, input logic [1:0] n, input bit arb);
    int k;
    @(negedge clk);
    {cmd, tx, num, valid, dclr} = {tw_cmd_t'(c), d, n, 2'h3};
    @(negedge clk);
    {valid, dclr} = 2'h0;
    check("tip", st.tip, 1);
    if (arb)
    begin
      @(negedge scl_w);
      @(negedge clk);
      tb_pull = 1'b1;
    end
    k = 0;
    while (st.tip === 1'b1 && k < 60000)
    begin
      @(negedge clk);
      k++;
    end
    check("done", st.done, 1);
  endtask : run
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic t_bare_start;
    @(negedge clk);
    {cmd, valid} = {tw_cmd_t'(5'h10), 1'b1};
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
    check("bare tip", st.tip, 0);
  endtask : t_bare_start
  task automatic t_write4;
    stretch = 1'b1;
    run(5'h1A, 32'h815AC354, 2'h3, 0);
    stretch = 1'b0;
    check("rxack", st.rxack, 0);
    check("last byte", last, 8'h81);
    check("idle", {st.busy, scl_oe, sda_oe}, 0);
  endtask : t_write4
  task automatic t_read;
    run(5'h12, 32'h54, 2'h0, 0);
    check("owned", {st.busy, scl_oe}, 2'h3);
    run(5'h12, 32'h55, 2'h0, 0);
    check("rd rxack", st.rxack, 0);
    run(5'h0D, 32'h0, 2'h0, 0);
    check("rx", rx, 8'hA5);
    check("rd idle", {st.busy, sda_oe}, 0);
  endtask : t_read
  task automatic t_nack_std;
    fast = 1'b0;
    run(5'h1A, 32'h40, 2'h1, 0);
    fast = 1'b1;
    check("nack", {st.rxack, scl_oe, sda_oe}, 3'h4);
  endtask : t_nack_std
  task automatic t_arb;
    run(5'h12, 32'hAA, 2'h0, 1);
    check("lost", {st.al, st.done, scl_oe, sda_oe}, 4'hC);
    @(negedge clk);
    {tb_pull, aclr} = 2'h1;
    @(negedge clk);
    aclr = 1'b0;
    @(negedge clk);
    check("al clr", st.al, 0);
  endtask : t_arb
  // ********************
  // Sequence
  // ********************
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("reset", {st, rx, scl_oe, sda_oe}, 0);
    t_bare_start();
    t_write4();
    t_read();
    t_nack_std();
    t_arb();
    report_and_stop();
  end
  initial
  begin
    #450000;
    n_errors++;
    report_and_stop();
  end
endmodule : tw_master_tb
`default_nettype wire
